/* core/pm_clk_pkg.sv */
package pm_clk_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 20000000;
  localparam int unsigned SETTLE_MS   = 1;
  localparam int unsigned SETTLE_CYC  = SETTLE_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned WAKE_US     = 10;
  localparam int unsigned WAKE_CYC    = WAKE_US * (CLK_FREQ_HZ / 1000000);
  localparam logic [1:0]  GAP_CYC     = 2'h2;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] OFS_OSC_CTRL = 4'h0;
  localparam logic [3:0] OFS_TMR_CTRL = 4'h4;
  localparam logic [3:0] OFS_PM_CFG   = 4'h8;

  localparam int IDLE_EN_BIT  = 7;
  localparam int FREQ_LSB     = 4;
  localparam int PRI_RDY_BIT  = 3;
  localparam int INT_STBL_BIT = 2;
  localparam int CSS_LSB      = 0;
  localparam int SEC_ACT_BIT  = 6;
  localparam int SEC_EN_BIT   = 3;
  localparam int WDT_EN_BIT   = 0;
  localparam int FSCM_EN_BIT  = 1;

  localparam logic [7:0] OSC_CTRL_RST = 8'h00;
  localparam logic [7:0] TMR_CTRL_RST = 8'h00;
  localparam logic [7:0] PM_CFG_RST   = 8'h00;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic [2:0] clk_src_t;
  localparam clk_src_t SRC_NONE = 3'h0;
  localparam clk_src_t SRC_PRI  = 3'h1;
  localparam clk_src_t SRC_SEC  = 3'h2;
  localparam clk_src_t SRC_INT  = 3'h4;

  typedef enum logic [5:0] {
    ST_PRIMARY_RUN_MODE = 6'h01,
    ST_ALT_RUN = 6'h02,
    ST_IDLE    = 6'h04,
    ST_SLEEP   = 6'h08,
    ST_WAKE    = 6'h10,
    ST_SWITCH  = 6'h20
  } pm_state_e;

  typedef struct packed {
    logic     cpu_en;
    logic     periph_en;
    clk_src_t sel;
  } clk_ctl_s;

  typedef struct packed {
    logic primary;
    logic secondary;
    logic internal_osc_mux_out;
    logic lf_rc;
  } osc_en_s;

  localparam clk_ctl_s CLK_CTL_RST = 5'h00;
  localparam osc_en_s  OSC_EN_RST  = 4'h8;

endpackage : pm_clk_pkg

/* core/power_mode_clock_switch.sv */
`timescale 1ns/1ps
`default_nettype none

module power_mode_clock_switch
  import pm_clk_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // CPU events
  input  wire logic        sleep_instr_i,
  input  wire logic        interrupt_i,
  input  wire logic        watchdog_timeout_i,
  // Oscillator status pins
  input  wire logic        primary_osc_ready_i,
  input  wire logic        secondary_osc_running_i,
  // Clock control
  output clk_ctl_s         clk_ctl_o,
  output osc_en_s          osc_en_o,
  output logic      [2:0]  internal_freq_o,
  output logic             watchdog_reset_o
);

  // ----------------------------------------
  // Decoding helpers
  // ----------------------------------------
  function automatic clk_src_t dec_src(input logic [1:0] css);
    dec_src = css[1] ? SRC_INT : (css[0] ? SRC_SEC : SRC_PRI);
  endfunction : dec_src

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic        pri_rdy_m;
  logic        pri_rdy_s;
  logic        secondary_run_mode_m;
  logic        secondary_run_mode_s;
  logic        idle_enable;
  logic [1:0]  clock_source_select;
  logic [2:0]  internal_freq_select;
  logic        primary_ready_flag;
  logic        internal_osc_stable_flag;
  logic        secondary_clock_active;
  logic        secondary_osc_enable;
  logic        wdt_en;
  logic        fscm_en;
  pm_state_e   state;
  pm_state_e   next_state;
  clk_src_t    src;
  clk_src_t    clk_sel;
  logic [1:0]  gap_cnt;
  logic [7:0]  wake_cnt;
  logic [15:0] settle_cnt;
  logic        int_pre;
  logic        cpu_en;
  logic        periph_en;
  osc_en_s     next_osc_en;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pri_rdy_m <= 1'b0;
      pri_rdy_s <= 1'b0;
      secondary_run_mode_m <= 1'b0;
      secondary_run_mode_s <= 1'b0;
    end
    else
    begin
      pri_rdy_m <= primary_osc_ready_i;
      pri_rdy_s <= pri_rdy_m;
      secondary_run_mode_m <= secondary_osc_running_i;
      secondary_run_mode_s <= secondary_run_mode_m;
    end
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire       bus_req  = avs_read_i | avs_write_i;
  wire       bus_done = bus_req & ~avs_waitrequest_o;
  wire       bus_wr   = avs_write_i & bus_done & avs_byteenable_i[0];
  wire       wr_osc   = bus_wr & (avs_address_i == OFS_OSC_CTRL);
  wire       wr_tmr   = bus_wr & (avs_address_i == OFS_TMR_CTRL);
  wire       wr_cfg   = bus_wr & (avs_address_i == OFS_PM_CFG);
  wire [7:0] wd       = avs_writedata_i[7:0];

  wire [7:0] osc_word = {idle_enable, internal_freq_select, primary_ready_flag,
                         internal_osc_stable_flag, clock_source_select};
  wire [7:0] tmr_word = {1'b0, secondary_clock_active, 2'h0,
                         secondary_osc_enable, 3'h0};
  wire [7:0] cfg_word = {6'h00, fscm_en, wdt_en};
  // Unmapped addresses read as zero and ignore writes
  wire [7:0] rd_byte  = (avs_address_i == OFS_OSC_CTRL) ? osc_word :
                        (avs_address_i == OFS_TMR_CTRL) ? tmr_word :
                        (avs_address_i == OFS_PM_CFG)   ? cfg_word : 8'h00;

  // One wait state on every access
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
      if (avs_read_i & avs_waitrequest_o)
        avs_readdata_o <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  // Only the bus writes the control bits; no mode change touches them
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      idle_enable          <= OSC_CTRL_RST[IDLE_EN_BIT];
      internal_freq_select <= OSC_CTRL_RST[FREQ_LSB +: 3];
      clock_source_select  <= OSC_CTRL_RST[CSS_LSB +: 2];
      secondary_osc_enable <= TMR_CTRL_RST[SEC_EN_BIT];
      wdt_en               <= PM_CFG_RST[WDT_EN_BIT];
      fscm_en              <= PM_CFG_RST[FSCM_EN_BIT];
    end
    else
    begin
      if (wr_osc)
      begin
        idle_enable          <= wd[IDLE_EN_BIT];
        internal_freq_select <= wd[FREQ_LSB +: 3];
        clock_source_select  <= wd[CSS_LSB +: 2];
      end
      if (wr_tmr)
        secondary_osc_enable <= wd[SEC_EN_BIT];
      if (wr_cfg)
      begin
        wdt_en  <= wd[WDT_EN_BIT];
        fscm_en <= wd[FSCM_EN_BIT];
      end
    end
  end

  // ----------------------------------------
  // Mode events
  // ----------------------------------------
  wire      in_pri    = (state == ST_PRIMARY_RUN_MODE);
  wire      in_alt    = (state == ST_ALT_RUN);
  wire      in_idle   = (state == ST_IDLE);
  wire      in_sleep  = (state == ST_SLEEP);
  wire      in_wake   = (state == ST_WAKE);
  wire      in_switch = (state == ST_SWITCH);
  wire      css_zero  = (clock_source_select == 2'h0);
  wire      freq_nz   = |internal_freq_select;
  clk_src_t tgt;
  assign tgt = dec_src(clock_source_select);

  wire sec_drop   = (src == SRC_SEC) & ~secondary_osc_enable;
  wire run_exit   = in_alt & (interrupt_i | sec_drop);
  wire sleep_ok   = sleep_instr_i & (in_pri | (in_alt & ~run_exit));
  wire sleep_full = sleep_ok & ~idle_enable & css_zero;
  wire sleep_hold = sleep_ok & idle_enable & in_alt;
  wire sleep_pidl = sleep_ok & idle_enable & css_zero & in_pri;
  wire sleep_skip = sleep_ok & ~sleep_hold & (tgt == SRC_SEC)
                    & ~secondary_osc_enable;
  wire sleep_alt  = sleep_ok & ~sleep_full & ~sleep_hold
                    & ~sleep_pidl & ~sleep_skip;
  wire wake_evt   = interrupt_i | watchdog_timeout_i;
  wire wake_idle  = in_idle & wake_evt;
  wire wake_sleep = in_sleep & wake_evt;
  // A running CPU is a run mode, switchback after a wake included
  wire wdt_rst    = cpu_en & watchdog_timeout_i;
  wire wake_done  = in_wake & (wake_cnt == 8'(WAKE_CYC - 1));
  wire sw_done    = in_switch & (clk_sel == SRC_PRI);
  wire int_wr_nz  = wr_osc & (|wd[FREQ_LSB +: 3]) & in_pri;

  // ----------------------------------------
  // Mode state machine
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      ST_PRIMARY_RUN_MODE, ST_ALT_RUN:
      begin
        if (run_exit)
          next_state = ST_SWITCH;
        else if (sleep_full)
          next_state = ST_SLEEP;
        else if (sleep_hold | sleep_pidl)
          next_state = ST_IDLE;
        else if (sleep_alt)
          next_state = idle_enable ? ST_IDLE : ST_ALT_RUN;
      end
      ST_IDLE:
        if (wake_idle)
          next_state = ST_WAKE;
      ST_WAKE:
        if (wake_done)
          next_state = (src == SRC_PRI) ? ST_PRIMARY_RUN_MODE : ST_SWITCH;
      ST_SLEEP:
        if (wake_sleep)
          next_state = ST_SWITCH;
      ST_SWITCH:
        if (sw_done)
          next_state = ST_PRIMARY_RUN_MODE;
      default:
        next_state = ST_SWITCH;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state <= ST_SWITCH;
    else
      state <= next_state;
  end

  // Requested source; idle entry from alternate run or with CSS zero leaves it alone
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      src <= SRC_PRI;
    else if (sleep_full)
      src <= SRC_NONE;
    else if (sleep_alt)
      src <= tgt;
    else if (wake_sleep | (in_switch & pri_rdy_s))
      src <= SRC_PRI;
  end

  // ----------------------------------------
  // Glitch-free source switch
  // ----------------------------------------
  // Break before make: the old select drops, the mux idles for a gap, then
  // the new one is raised once the primary or secondary reports running; the internal mux needs no report.
  wire src_ok = (src == SRC_PRI) ? pri_rdy_s :
                (src == SRC_SEC) ? secondary_run_mode_s : 1'b1;

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      clk_sel <= SRC_NONE;
      gap_cnt <= 2'h0;
    end
    else if (clk_sel != src)
    begin
      if (clk_sel != SRC_NONE)
      begin
        clk_sel <= SRC_NONE;
        gap_cnt <= 2'h0;
      end
      else if (gap_cnt != GAP_CYC)
        gap_cnt <= gap_cnt + 2'h1;
      else if (src_ok)
        clk_sel <= src;
    end
  end

  // ----------------------------------------
  // CPU and peripheral clock gates
  // ----------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cpu_en    <= 1'b0;
      periph_en <= 1'b0;
    end
    else
    begin
      if (sleep_full | sleep_pidl | sleep_hold | (sleep_alt & idle_enable))
        cpu_en <= 1'b0;
      else if (wake_done | sw_done)
        cpu_en <= 1'b1;
      if (sleep_full)
        periph_en <= 1'b0;
      else if (sw_done)
        periph_en <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      wake_cnt <= 8'h00;
    else if (in_wake)
      wake_cnt <= wake_cnt + 8'h01;
    else
      wake_cnt <= 8'h00;
  end

  // ----------------------------------------
  // Internal oscillator settling
  // ----------------------------------------
  // Mux output runs only with a nonzero frequency select and a user for it
  wire int_live   = freq_nz & ((src == SRC_INT) | (clk_sel == SRC_INT) | int_pre);
  wire settle_hit = (settle_cnt == 16'(SETTLE_CYCLES - 1));

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      int_pre <= 1'b0;
    else if (sleep_full | sw_done)
      int_pre <= 1'b0;
    else if (int_wr_nz)
      int_pre <= 1'b1;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      settle_cnt <= 16'h0000;
    else if (int_live & ~internal_osc_stable_flag & ~settle_hit)
      settle_cnt <= settle_cnt + 16'h0001;
    else
      settle_cnt <= 16'h0000;
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      primary_ready_flag       <= 1'b0;
      internal_osc_stable_flag <= 1'b0;
      secondary_clock_active   <= 1'b0;
    end
    else
    begin
      if (sw_done)
        primary_ready_flag <= 1'b1;
      else if (sleep_full | sleep_alt)
        primary_ready_flag <= 1'b0;
      internal_osc_stable_flag <= ~sw_done & ~sleep_full & int_live
        & (internal_osc_stable_flag | settle_hit);
      if (sleep_alt & (tgt == SRC_SEC))
        secondary_clock_active <= 1'b1;
      else if (sleep_full | sw_done | sleep_alt)
        secondary_clock_active <= 1'b0;
    end
  end

  // ----------------------------------------
  // Oscillator enables
  // ----------------------------------------
  assign next_osc_en.primary    = (src == SRC_PRI) | (clk_sel == SRC_PRI)
                                  | in_switch | in_wake;
  assign next_osc_en.secondary  = secondary_osc_enable | (src == SRC_SEC)
                                  | (clk_sel == SRC_SEC);
  assign next_osc_en.internal_osc_mux_out = int_live;
  assign next_osc_en.lf_rc      = wdt_en | (~in_sleep & (fscm_en
                                  | (((src == SRC_INT) | (clk_sel == SRC_INT))
                                     & ~freq_nz)));

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      clk_ctl_o        <= CLK_CTL_RST;
      osc_en_o         <= OSC_EN_RST;
      internal_freq_o  <= OSC_CTRL_RST[FREQ_LSB +: 3];
      watchdog_reset_o <= 1'b0;
    end
    else
    begin
      clk_ctl_o        <= '{cpu_en: cpu_en, periph_en: periph_en, sel: clk_sel};
      osc_en_o         <= next_osc_en;
      internal_freq_o  <= internal_freq_select;
      watchdog_reset_o <= wdt_rst;
    end
  end

endmodule : power_mode_clock_switch

`default_nettype wire

/* tb/power_mode_clock_switch_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Checker
// ----------------------------------------
module power_mode_clock_switch_sva
  import pm_clk_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
) (
  input wire logic        core_clk_i,
  input wire logic        resetn_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        watchdog_timeout_i,
  input wire logic        interrupt_i,
  input wire clk_ctl_s    clk_ctl_o,
  input wire osc_en_s     osc_en_o,
  input wire logic [2:0]  internal_freq_o,
  input wire logic        watchdog_reset_o
);
  // Halted-CPU cycles since the wake event, saturating so a long idle cannot wrap
  logic [8:0] low_cnt;
  always_ff @(posedge core_clk_i or negedge resetn_i)
    if (!resetn_i) low_cnt <= 9'h000;
    else if (clk_ctl_o.cpu_en || !clk_ctl_o.periph_en) low_cnt <= 9'h000;
    else if (interrupt_i || watchdog_timeout_i) low_cnt <= 9'h000;
    else if (low_cnt != 9'h1ff) low_cnt <= low_cnt + 9'h001;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  property p_one_wait;
    (avs_read_i || avs_write_i) && !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus answer longer than one cycle");
  property p_wdt_reset;
    $past(watchdog_timeout_i) && clk_ctl_o.cpu_en |-> watchdog_reset_o;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("run mode time-out gave no reset");
  property p_wdt_cause;
    watchdog_reset_o |-> $past(watchdog_timeout_i) && clk_ctl_o.cpu_en;
  endproperty
  a_wdt_cause: assert property (p_wdt_cause) else $error("watchdog reset without run time-out");
  property p_run_both;
    clk_ctl_o.cpu_en |-> clk_ctl_o.periph_en;
  endproperty
  a_run_both: assert property (p_run_both) else $error("CPU clocked without peripherals");
  property p_gap;
    clk_ctl_o.sel != SRC_NONE && $past(clk_ctl_o.sel) != clk_ctl_o.sel
      |-> $past(clk_ctl_o.sel) == SRC_NONE && $past(clk_ctl_o.sel, 2) == SRC_NONE;
  endproperty
  a_gap: assert property (p_gap) else $error("clock switch without idle gap");
  property p_wake_delay;
    $rose(clk_ctl_o.cpu_en) && $past(clk_ctl_o.periph_en) |-> low_cnt >= WAKE_CYC;
  endproperty
  a_wake_delay: assert property (p_wake_delay) else $error("CPU resumed too early");
  property p_freq_zero;
    internal_freq_o == 3'h0 && $past(internal_freq_o) == 3'h0 |-> !osc_en_o.internal_osc_mux_out;
  endproperty
  a_freq_zero: assert property (p_freq_zero) else $error("mux output on with zero frequency");
  property p_int_entry;
    clk_ctl_o.sel == SRC_INT && $past(clk_ctl_o.sel) == SRC_NONE |-> !osc_en_o.primary;
  endproperty
  a_int_entry: assert property (p_int_entry) else $error("primary left on in mux mode");
  property p_sec_on;
    clk_ctl_o.sel == SRC_SEC |-> osc_en_o.secondary;
  endproperty
  a_sec_on: assert property (p_sec_on) else $error("secondary selected but stopped");
  property p_sleep_off;
    !clk_ctl_o.periph_en && $past(!clk_ctl_o.periph_en) && !osc_en_o.primary |-> !osc_en_o.internal_osc_mux_out;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("mux running in sleep");

  c_wdt: cover property ($rose(watchdog_reset_o));
  c_sec: cover property (clk_ctl_o.sel == SRC_SEC);
  c_idle: cover property (!clk_ctl_o.cpu_en && clk_ctl_o.periph_en);
endmodule : power_mode_clock_switch_sva

bind power_mode_clock_switch power_mode_clock_switch_sva #(.SETTLE_CYCLES(SETTLE_CYCLES))
  power_mode_clock_switch_sva_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .watchdog_timeout_i(watchdog_timeout_i),
  .interrupt_i(interrupt_i),
  .clk_ctl_o(clk_ctl_o), .osc_en_o(osc_en_o), .internal_freq_o(internal_freq_o),
  .watchdog_reset_o(watchdog_reset_o));
`default_nettype wire

/* tb/power_mode_clock_switch_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module power_mode_clock_switch_tb_top
  import pm_clk_pkg::*;
;
  localparam int unsigned SETTLE = 50;
  // Primary start-up longer than the wake delay, so the CPU is seen on the low-power source
  localparam int PRI_DLY = 400;
  logic        clk, resetn, rd, wr, wreq, sleep, intr, wdt, pri_rdy, secondary_run_mode, wdt_rst;
  logic [3:0]  addr, be;
  logic [31:0] wdata, rdata;
  clk_ctl_s    ctl;
  osc_en_s     osc;
  logic [2:0]  ifreq;
  int          pcnt, bad_count, checks;

  power_mode_clock_switch #(.SETTLE_CYCLES(SETTLE)) power_mode_clock_switch_i (
    .core_clk_i(clk), .resetn_i(resetn), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .sleep_instr_i(sleep), .interrupt_i(intr), .watchdog_timeout_i(wdt), .primary_osc_ready_i(pri_rdy),
    .secondary_osc_running_i(secondary_run_mode), .clk_ctl_o(ctl), .osc_en_o(osc), .internal_freq_o(ifreq),
    .watchdog_reset_o(wdt_rst));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Oscillators answer their enables; primary needs a start-up time
  always @(posedge clk)
  begin
    secondary_run_mode <= osc.secondary;
    pcnt <= osc.primary ? ((pcnt < PRI_DLY) ? pcnt + 1 : pcnt) : 0;
    pri_rdy <= osc.primary && (pcnt >= PRI_DLY);
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // Request held until the rising edge that sees waitrequest low; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    wdata <= {24'h00_0000, d};
    wr <= w;
    rd <= !w;
    @(posedge clk);
    while (wreq !== 1'b0)
      @(posedge clk);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr_reg

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q & {24'h00_0000, m}, {24'h00_0000, e});
  endtask : rd_chk

  task automatic wait_ctl(input clk_ctl_s e);
    int n;
    n = 0;
    while (ctl !== e && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    chk(32'(ctl), 32'(e));
  endtask : wait_ctl

  task automatic ev(input int k);
    @(posedge clk);
    sleep <= (k == 0);
    intr <= (k == 1);
    wdt <= (k == 2);
    @(posedge clk);
    {sleep, intr, wdt} <= 3'h0;
  endtask : ev

  initial
  begin
    {addr, rd, wr, wdata, sleep, intr, wdt, resetn} = '0;
    be = 4'hf;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(OFS_TMR_CTRL, 8'hff, TMR_CTRL_RST);
    rd_chk(OFS_PM_CFG, 8'hff, PM_CFG_RST);
    rd_chk(4'hc, 8'hff, 8'h00);
    wait_ctl({2'b11, SRC_PRI});
    rd_chk(OFS_OSC_CTRL, 8'hff, 8'h08);
    ev(2);
    @(negedge clk);
    chk(32'(wdt_rst), 32'h0000_0001);
    $display("test reset done");
    wr_reg(OFS_PM_CFG, 8'h01);
    wr_reg(OFS_OSC_CTRL, 8'h53);
    repeat (SETTLE + 20) @(posedge clk);
    rd_chk(OFS_OSC_CTRL, 8'hff, 8'h5f);
    ev(0);
    wait_ctl({2'b11, SRC_INT});
    chk(32'(osc.primary), 32'h0000_0000);
    rd_chk(OFS_OSC_CTRL, 8'hff, 8'h57);
    wr_reg(OFS_OSC_CTRL, 8'h03);
    repeat (3) @(negedge clk);
    chk(32'(ifreq), 32'h0000_0000);
    chk(32'(osc.lf_rc), 32'h0000_0001);
    chk(32'(osc.internal_osc_mux_out), 32'h0000_0000);
    rd_chk(OFS_OSC_CTRL, 8'hff, 8'h03);
    wr_reg(OFS_OSC_CTRL, 8'h53);
    repeat (3) @(negedge clk);
    chk(32'(ifreq), 32'h0000_0005);
    chk(32'(ctl), 32'({2'b11, SRC_INT}));
    repeat (SETTLE + 20) @(posedge clk);
    rd_chk(OFS_OSC_CTRL, 8'hff, 8'h57);
    chk(32'(osc.internal_osc_mux_out), 32'h0000_0001);
    ev(1);
    wait_ctl({2'b11, SRC_PRI});
    rd_chk(OFS_OSC_CTRL, 8'hff, 8'h5b);
    chk(32'(osc.lf_rc), 32'h0000_0001);
    $display("test internal run done");
    wr_reg(OFS_OSC_CTRL, 8'hd3);
    ev(0);
    wait_ctl({2'b01, SRC_INT});
    rd_chk(OFS_OSC_CTRL, 8'hfb, 8'hd3);
    ev(1);
    repeat (150) @(negedge clk);
    chk(32'(ctl), 32'({2'b01, SRC_INT}));
    wait_ctl({2'b11, SRC_INT});
    wait_ctl({2'b11, SRC_PRI});
    rd_chk(OFS_OSC_CTRL, 8'hfb, 8'hdb);
    $display("test internal idle done");
    wr_reg(OFS_OSC_CTRL, 8'h01);
    ev(0);
    repeat (20) @(negedge clk);
    chk(32'(ctl), 32'({2'b11, SRC_PRI}));
    wr_reg(OFS_TMR_CTRL, 8'h08);
    repeat (10) @(posedge clk);
    ev(0);
    wait_ctl({2'b11, SRC_SEC});
    rd_chk(OFS_TMR_CTRL, 8'hff, 8'h48);
    rd_chk(OFS_OSC_CTRL, 8'hfb, 8'h01);
    wr_reg(OFS_OSC_CTRL, 8'h81);
    ev(0);
    repeat (5) @(negedge clk);
    chk(32'(ctl), 32'({2'b01, SRC_SEC}));
    rd_chk(OFS_TMR_CTRL, 8'hff, 8'h48);
    ev(1);
    wait_ctl({2'b11, SRC_SEC});
    wait_ctl({2'b11, SRC_PRI});
    rd_chk(OFS_TMR_CTRL, 8'hff, 8'h08);
    chk(32'(osc.secondary), 32'h0000_0001);
    wr_reg(OFS_OSC_CTRL, 8'h01);
    ev(0);
    wait_ctl({2'b11, SRC_SEC});
    wr_reg(OFS_TMR_CTRL, 8'h00);
    repeat (50) @(negedge clk);
    chk(32'(ctl), 32'({2'b11, SRC_SEC}));
    wait_ctl({2'b11, SRC_PRI});
    rd_chk(OFS_TMR_CTRL, 8'hff, 8'h00);
    chk(32'(osc.secondary), 32'h0000_0000);
    $display("test secondary done");
    wr_reg(OFS_OSC_CTRL, 8'h50);
    ev(0);
    repeat (10) @(negedge clk);
    chk(32'(ctl), 32'h0000_0000);
    chk(32'(osc), 32'h0000_0001);
    rd_chk(OFS_OSC_CTRL, 8'hff, 8'h50);
    ev(2);
    @(negedge clk);
    chk(32'(wdt_rst), 32'h0000_0000);
    wait_ctl({2'b11, SRC_PRI});
    rd_chk(OFS_OSC_CTRL, 8'hfb, 8'h58);
    $display("test sleep done");
    summarize();
  end

  initial
  begin
    #(50 * 20000);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    summarize();
  end
endmodule : power_mode_clock_switch_tb_top
`default_nettype wire
